// ==== ubt_core.sv ====
`timescale 1ns/1ps
`default_nettype none

module ubt_core
  import ubt_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic              rx_valid_in,
  input  wire logic [CHR_W-1:0]  rx_char_in,
  input  wire logic              rx_command_in,
  input  wire logic              tx_done_in,
  input  wire logic              sck_in,
  input  wire logic              sc_error_in,
  output logic                   tx_load_out,
  output logic      [CHR_W-1:0]  tx_char_out,
  output logic                   tx_command_out,
  output logic                   bit_tick_out,
  output logic                   sample_tick_out,
  output logic      [IRF_W-1:0]  irda_filter_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // High on the tick that completes a count of val; val of zero never fires
  function automatic logic last_tick(input logic [15:0] cnt,
                                     input logic [15:0] val);
    last_tick = (val != 16'h0000) && (cnt == val - 16'h0001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [2:0]          mode_q;
  logic [CD_W-1:0]     clock_divider_q;
  logic [FP_W-1:0]     fractional_part_q;
  logic [TO_W-1:0]     rx_timeout_value_q;
  logic [TG_W-1:0]     guard_time_value_q;
  logic [RATIO_W-1:0]  smartcard_clock_ratio_value_q;
  logic [ERR_W-1:0]    error_count_q;
  logic [ERR_W-1:0]    error_count_d;
  logic [IRF_W-1:0]    irda_filter_q;
  logic [CHR_W-1:0]    rx_char_q;
  logic                received_command_flag_q;
  logic                rx_ready_q;
  logic                rx_ready_d;
  logic [CHR_W-1:0]    transmit_character_q;
  logic                transmit_command_flag_q;
  logic                hold_full_q;
  logic                hold_full_d;
  logic [DATA_W-1:0]   rd_mux;
  logic [DATA_W-1:0]   rdata_q;
  wire wr_mode   = reg_wr_in && (reg_addr_in == OFS_MODE);
  wire wr_ctrl   = reg_wr_in && (reg_addr_in == OFS_CTRL);
  wire wr_thold  = reg_wr_in && (reg_addr_in == OFS_THOLD);
  wire wr_baud   = reg_wr_in && (reg_addr_in == OFS_BAUD);
  wire wr_rto    = reg_wr_in && (reg_addr_in == OFS_RTO);
  wire wr_guard  = reg_wr_in && (reg_addr_in == OFS_GUARD);
  wire wr_ratio  = reg_wr_in && (reg_addr_in == OFS_RATIO);
  wire wr_irf    = reg_wr_in && (reg_addr_in == OFS_IRF);
  wire rd_rhold  = reg_rd_in && (reg_addr_in == OFS_RHOLD);
  wire rd_errcnt = reg_rd_in && (reg_addr_in == OFS_ERRCNT);
  wire start_cmd = wr_ctrl && reg_wdata_in[CTRL_STTO_B];
  wire mode_sync = mode_q[MODE_SYNC_B];
  wire mode_over = mode_q[MODE_OVER_B];
  wire mode_sc   = mode_q[MODE_SC_B];
  ////////////////////////////////////////////////////////////////////////////
  // Baud rate generator
  logic [CD_W-1:0]    div_cnt_q;
  logic               extra_q;
  logic [FP_W-1:0]    frac_acc_q;
  logic [OS_W-1:0]    os_cnt_q;
  logic [RATIO_W-1:0] ratio_cnt_q;
  logic               sck_prev_q;
  logic               bit_tick_q;
  logic               sample_tick_q;
  wire baud_on = clock_divider_q != '0;
  wire div_end = baud_on &&
                 (div_cnt_q == (extra_q ? clock_divider_q
                                        : clock_divider_q - 16'h0001));
  wire [CD_W-1:0] div_cnt_d = div_end ? '0 : div_cnt_q + 16'h0001;
  wire [FP_W:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, fractional_part_q};
  wire          extra_d  = frac_sum[FP_W] && !mode_sync;
  wire [OS_W-1:0] os_last  = mode_over ? OS8_LAST : OS16_LAST;
  wire            os_wrap  = os_cnt_q == os_last;
  wire            async_end = div_end && os_wrap;
  wire [OS_W-1:0] os_cnt_d = os_wrap ? '0 : os_cnt_q + 4'h1;
  wire sck_rise = sck_in && !sck_prev_q;
  wire sc_end   = sck_rise &&
                  last_tick({5'h00, ratio_cnt_q},
                            {5'h00, smartcard_clock_ratio_value_q});
  wire ratio_on = smartcard_clock_ratio_value_q != '0;
  wire [RATIO_W-1:0] ratio_cnt_d = sc_end ? '0 : ratio_cnt_q + 11'h001;
  wire bit_tick_d = mode_sc   ? sc_end   :
                    mode_sync ? div_end  : async_end;
  wire samp_d     = mode_sc   ? sc_end   : div_end;
  // Restart on a new setting, or a count above a smaller divider runs the full range
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !baud_on || wr_baud || wr_mode) begin
      div_cnt_q  <= '0;
      extra_q    <= 1'b0;
      frac_acc_q <= '0;
      os_cnt_q   <= '0;
    end else if (div_end) begin
      div_cnt_q  <= div_cnt_d;
      extra_q    <= extra_d;
      frac_acc_q <= frac_sum[FP_W-1:0];
      os_cnt_q   <= os_cnt_d;
    end else begin
      div_cnt_q  <= div_cnt_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !ratio_on || wr_ratio) begin
      ratio_cnt_q <= '0;
    end else if (sck_rise) begin
      ratio_cnt_q <= ratio_cnt_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sck_prev_q    <= 1'b0;
      bit_tick_q    <= 1'b0;
      sample_tick_q <= 1'b0;
    end else begin
      sck_prev_q    <= sck_in;
      bit_tick_q    <= bit_tick_d;
      sample_tick_q <= samp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding and timeguard
  ubt_tx_state_t     tx_state_q;
  ubt_tx_state_t     tx_state_d;
  logic [TG_W-1:0]   guard_cnt_q;
  logic              tx_load_q;
  logic [CHR_W-1:0]  tx_char_q;
  logic              tx_cmd_q;
  wire guard_done = bit_tick_d &&
                    last_tick({8'h00, guard_cnt_q}, {8'h00, guard_time_value_q});
  wire tx_load_d  = (tx_state_q == TX_IDLE) && hold_full_q;
  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TX_IDLE: begin
        if (hold_full_q) begin
          tx_state_d = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_done_in) begin
          tx_state_d = (guard_time_value_q == '0) ? TX_IDLE : TX_GUARD;
        end
      end
      TX_GUARD: begin
        if (guard_done || guard_time_value_q == '0) begin
          tx_state_d = TX_IDLE;
        end
      end
      default: begin
        tx_state_d = TX_IDLE;
      end
    endcase
  end

  // ready mirrors holding
  // A write while full replaces the waiting character; set beats load
  assign hold_full_d = wr_thold ? 1'b1 : (tx_load_d ? 1'b0 : hold_full_q);
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || tx_state_q != TX_GUARD) begin
      guard_cnt_q <= '0;
    end else if (bit_tick_d) begin
      guard_cnt_q <= guard_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_state_q  <= TX_IDLE;
      hold_full_q <= 1'b0;
      tx_load_q   <= 1'b0;
      tx_char_q   <= '0;
      tx_cmd_q    <= 1'b0;
    end else begin
      tx_state_q  <= tx_state_d;
      hold_full_q <= hold_full_d;
      tx_load_q   <= tx_load_d;
      if (tx_load_d) begin
        tx_char_q <= transmit_character_q;
        tx_cmd_q  <= transmit_command_flag_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver time-out
  logic [TO_W-1:0] to_cnt_q;
  logic            to_armed_q;
  logic            to_flag_q;
  wire to_hit = to_armed_q && bit_tick_d && last_tick(to_cnt_q, rx_timeout_value_q);
  wire to_off = rx_timeout_value_q == '0;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || start_cmd || rx_valid_in || !to_armed_q) begin
      to_cnt_q <= '0;
    end else if (bit_tick_d) begin
      to_cnt_q <= to_cnt_q + 16'h0001;
    end
  end

  // flag after delay
  // Expiry in the cycle of a start command still sets the flag
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || to_off) begin
      to_armed_q <= 1'b0;
      to_flag_q  <= 1'b0;
    end else begin
      to_armed_q <= start_cmd || (to_armed_q && !to_hit);
      to_flag_q  <= to_hit || (to_flag_q && !start_cmd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding and error count
  // Arrival beats clear on the same cycle
  assign rx_ready_d = rx_valid_in || (rx_ready_q && !rd_rhold);
  always_comb begin
    if (rd_errcnt) begin
      error_count_d = sc_error_in ? 8'h01 : '0;
    end else if (sc_error_in && error_count_q != ERR_MAX) begin
      error_count_d = error_count_q + 8'h01;
    end else begin
      error_count_d = error_count_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_char_q               <= '0;
      received_command_flag_q <= 1'b0;
      rx_ready_q              <= 1'b0;
      error_count_q           <= '0;
    end else begin
      rx_ready_q    <= rx_ready_d;
      error_count_q <= error_count_d;
      if (rx_valid_in) begin
        rx_char_q               <= rx_char_in;
        received_command_flag_q <= rx_command_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration writes
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mode_q                        <= '0;
      clock_divider_q               <= '0;
      fractional_part_q             <= '0;
      rx_timeout_value_q            <= '0;
      guard_time_value_q            <= '0;
      smartcard_clock_ratio_value_q <= RATIO_RST;
      irda_filter_q                 <= '0;
      transmit_character_q          <= '0;
      transmit_command_flag_q       <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata_in[2:0];
      end
      if (wr_baud) begin
        clock_divider_q   <= reg_wdata_in[CD_W-1:0];
        fractional_part_q <= reg_wdata_in[FP_LSB+FP_W-1:FP_LSB];
      end
      if (wr_rto) begin
        rx_timeout_value_q <= reg_wdata_in[TO_W-1:0];
      end
      if (wr_guard) begin
        guard_time_value_q <= reg_wdata_in[TG_W-1:0];
      end
      if (wr_ratio) begin
        smartcard_clock_ratio_value_q <= reg_wdata_in[RATIO_W-1:0];
      end
      if (wr_irf) begin
        irda_filter_q <= reg_wdata_in[IRF_W-1:0];
      end
      if (wr_thold) begin
        transmit_character_q    <= reg_wdata_in[CHR_W-1:0];
        transmit_command_flag_q <= reg_wdata_in[SYNH_B];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped and write-only offsets read zero
  always_comb begin
    rd_mux = '0;
    if (reg_addr_in == OFS_MODE) begin
      rd_mux[2:0] = mode_q;
    end else if (reg_addr_in == OFS_STATUS) begin
      rd_mux[STAT_RXRDY_B] = rx_ready_q;
      rd_mux[STAT_TRANSMITTER_READY_FLAG_B] = !hold_full_q;
      rd_mux[STAT_TOUT_B]  = to_flag_q;
    end else if (reg_addr_in == OFS_RHOLD) begin
      rd_mux[CHR_W-1:0] = rx_char_q;
      rd_mux[SYNH_B]    = received_command_flag_q;
    end else if (reg_addr_in == OFS_BAUD) begin
      rd_mux[CD_W-1:0]               = clock_divider_q;
      rd_mux[FP_LSB+FP_W-1:FP_LSB]   = fractional_part_q;
    end else if (reg_addr_in == OFS_RTO) begin
      rd_mux[TO_W-1:0] = rx_timeout_value_q;
    end else if (reg_addr_in == OFS_GUARD) begin
      rd_mux[TG_W-1:0] = guard_time_value_q;
    end else if (reg_addr_in == OFS_RATIO) begin
      rd_mux[RATIO_W-1:0] = smartcard_clock_ratio_value_q;
    end else if (reg_addr_in == OFS_ERRCNT) begin
      rd_mux[ERR_W-1:0] = error_count_q;
    end else if (reg_addr_in == OFS_IRF) begin
      rd_mux[IRF_W-1:0] = irda_filter_q;
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out   = rdata_q;
  assign tx_load_out     = tx_load_q;
  assign tx_char_out     = tx_char_q;
  assign tx_command_out  = tx_cmd_q;
  assign bit_tick_out    = bit_tick_q;
  assign sample_tick_out = sample_tick_q;
  assign irda_filter_out = irda_filter_q;

endmodule

`default_nettype wire

// ==== ubt_core_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module ubt_core_assertions
  import ubt_pkg::*;
(
  input wire logic              core_clk_in,
  input wire logic              sys_rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              rx_valid_in,
  input wire logic [CHR_W-1:0]  rx_char_in,
  input wire logic              rx_command_in,
  input wire logic              tx_done_in,
  input wire logic              sck_in,
  input wire logic              sc_error_in,
  input wire logic              tx_load_out,
  input wire logic [CHR_W-1:0]  tx_char_out,
  input wire logic              tx_command_out,
  input wire logic              bit_tick_out,
  input wire logic              sample_tick_out,
  input wire logic [IRF_W-1:0]  irda_filter_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [2:0]  mode_q;
  logic [18:0] baud_q;
  logic [15:0] to_q;
  logic [10:0] ratio_q;
  logic [7:0]  irf_q;
  logic [3:0]  age_q;
  logic [1:0]  tk_q;
  logic [19:0] gap_q;
  logic        pend_q;
  logic        busy_q;
  wire logic   cfg_w  = reg_wr_in && (reg_addr_in inside {OFS_MODE, OFS_BAUD, OFS_RTO,
                                                         OFS_RATIO, OFS_IRF});
  wire logic   hold_w = reg_wr_in && reg_addr_in == OFS_THOLD;

  // Periods are judged only from the third tick after a setting change
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mode_q  <= '0;
      baud_q  <= '0;
      to_q    <= '0;
      ratio_q <= RATIO_RST;
      irf_q   <= '0;
      age_q   <= '0;
      tk_q    <= '0;
      gap_q   <= '0;
      pend_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == OFS_MODE) mode_q <= reg_wdata_in[2:0];
      if (reg_wr_in && reg_addr_in == OFS_BAUD) baud_q <= reg_wdata_in[18:0];
      if (reg_wr_in && reg_addr_in == OFS_RTO) to_q <= reg_wdata_in[15:0];
      if (reg_wr_in && reg_addr_in == OFS_RATIO) ratio_q <= reg_wdata_in[10:0];
      if (reg_wr_in && reg_addr_in == OFS_IRF) irf_q <= reg_wdata_in[7:0];
      age_q  <= cfg_w ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      tk_q   <= cfg_w ? 2'h0 : tk_q + {1'b0, bit_tick_out && tk_q != 2'h2};
      gap_q  <= bit_tick_out ? 20'h1 : gap_q + 20'h1;
      pend_q <= hold_w || (pend_q && !tx_load_out);
      busy_q <= tx_load_out || (busy_q && !tx_done_in);
    end
  end

  sequence s_err_rd;
    reg_rd_in && reg_addr_in == OFS_ERRCNT && !sc_error_in;
  endsequence

  a_idle_cd_zero: assert property (
    age_q == 4'hF && !mode_q[MODE_SC_B] && baud_q[15:0] == 16'h0 |-> !bit_tick_out
  ) else $error("bit tick while divider is zero");
  a_idle_ratio_zero: assert property (
    age_q == 4'hF && mode_q[MODE_SC_B] && ratio_q == 11'h0 |-> !bit_tick_out
  ) else $error("bit tick while card ratio is zero");
  a_sync_bit_period: assert property (
    bit_tick_out && tk_q == 2'h2 && mode_q == 3'h1 |-> gap_q == {4'h0, baud_q[15:0]}
  ) else $error("sync bit period differs from divider");
  a_async_bit_period: assert property (
    bit_tick_out && tk_q == 2'h2 && !mode_q[0] && !mode_q[2] && baud_q[18:16] == 3'h0
    |-> gap_q == (mode_q[MODE_OVER_B] ? {1'b0, baud_q[15:0], 3'h0} : {baud_q[15:0], 4'h0})
  ) else $error("async bit period differs from divider");
  a_err_read_clear: assert property (
    s_err_rd ##1 s_err_rd |=> reg_rdata_out == 32'h0
  ) else $error("error count not cleared by read");
  a_filter_follows: assert property (
    age_q > 4'h1 |-> irda_filter_out == irf_q
  ) else $error("filter output differs from register");
  a_timeout_off: assert property (
    reg_rd_in && reg_addr_in == OFS_STATUS && to_q == 16'h0 && age_q > 4'h1
    |=> !reg_rdata_out[STAT_TOUT_B]
  ) else $error("time-out flag set while disabled");
  a_load_has_char: assert property (
    tx_load_out |-> pend_q
  ) else $error("load without a written character");
  a_load_when_idle: assert property (
    tx_load_out |-> !busy_q
  ) else $error("load before current character done");
endmodule

bind ubt_core ubt_core_assertions i_ubt_core_assertions (.*);

`default_nettype wire

// ==== ubt_core_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module ubt_core_test
  import ubt_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] r;
    logic [31:0] w;
    logic [31:0] e;
  } ubt_row_t;
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] baud;
    int          m;
    int          e;
  } ubt_per_t;

  logic              core_clk_in   = 1'b0;
  logic              sys_rst_in    = 1'b1;
  logic [ADDR_W-1:0] reg_addr_in   = '0;
  logic [DATA_W-1:0] reg_wdata_in  = '0;
  logic              reg_wr_in     = 1'b0;
  logic              reg_rd_in     = 1'b0;
  logic              rx_valid_in   = 1'b0;
  logic [CHR_W-1:0]  rx_char_in    = '0;
  logic              rx_command_in = 1'b0;
  logic              sc_error_in   = 1'b0;
  logic              sck_run       = 1'b0;
  wire logic [DATA_W-1:0] reg_rdata_out;
  wire logic [CHR_W-1:0]  tx_char_out;
  wire logic [IRF_W-1:0]  irda_filter_out;
  wire logic tx_done_in, sck_in, tx_load_out, tx_command_out, bit_tick_out, sample_tick_out;
  int          bad_count = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          n;
  logic [31:0] d;
  ubt_row_t rows [8] = '{
    '{OFS_STATUS, 32'h2, 32'hFFFF_FFFF, 32'h2},
    '{OFS_BAUD, 32'h0, 32'hFFFF_FFFF, 32'h0007_FFFF},
    '{OFS_RTO, 32'h0, 32'hFFFF_FFFF, 32'h0000_FFFF},
    '{OFS_GUARD, 32'h0, 32'hFFFF_FFFF, 32'h0000_00FF},
    '{OFS_RATIO, 32'h174, 32'hFFFF_FFFF, 32'h0000_07FF},
    '{OFS_IRF, 32'h0, 32'hFFFF_FFFF, 32'h0000_00FF},
    '{OFS_ERRCNT, 32'h0, 32'hFFFF_FFFF, 32'h0},
    '{8'h7C, 32'h0, 32'hFFFF_FFFF, 32'h0}
  };
  ubt_per_t pers [5] = '{
    '{32'h1, 32'h3, 4, 12},
    '{32'h0, 32'h2, 1, 32},
    '{32'h2, 32'h3, 1, 24},
    '{32'h2, 32'h0004_0002, 8, 160},
    '{32'h4, 32'h1, 1, 40}
  };

  ubt_core i_ubt_core (.*);
  ubt_partner #(.BITS(10)) i_ubt_partner (.core_clk_in, .sys_rst_in, .tx_load_in(tx_load_out),
    .bit_tick_in(bit_tick_out), .sck_run_in(sck_run), .tx_done_out(tx_done_in), .sck_out(sck_in));

  always #2 core_clk_in = ~core_clk_in;

  task automatic finish_test;
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= w;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge core_clk_in);
    v = reg_rdata_out;
  endtask

  task automatic rx(input logic c, input logic [8:0] ch);
    rx_valid_in   <= 1'b1;
    rx_command_in <= c;
    rx_char_in    <= ch;
    @(posedge core_clk_in);
    rx_valid_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // First two ticks after a change may still run on the old setting
  task automatic ticks(input int m, output int c);
    c = 0;
    repeat (2) do @(posedge core_clk_in); while (bit_tick_out !== 1'b1);
    repeat (m) do begin
      @(posedge core_clk_in);
      c++;
    end while (bit_tick_out !== 1'b1);
  endtask

  task automatic quiet(output int c);
    c = 0;
    repeat (20) @(posedge core_clk_in);
    repeat (60) begin
      @(posedge core_clk_in);
      if (bit_tick_out === 1'b1 || sample_tick_out === 1'b1) c++;
    end
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      chk(d, rows[i].r);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    chk({24'h0, irda_filter_out}, 32'hFF);
    wr(OFS_RATIO, 32'h5);
    wr(OFS_GUARD, 32'h0);
    foreach (pers[i]) begin
      sck_run <= pers[i].mode[MODE_SC_B];
      wr(OFS_MODE, pers[i].mode);
      wr(OFS_BAUD, pers[i].baud);
      ticks(pers[i].m, n);
      chk(n, pers[i].e);
    end
    wr(OFS_RATIO, 32'h0);
    quiet(n);
    chk(n, 0);
    sck_run <= 1'b0;
    wr(OFS_MODE, 32'h0);
    wr(OFS_BAUD, 32'h0);
    quiet(n);
    chk(n, 0);
    repeat (3) rx(1'b0, 9'h0);
    repeat (3) begin
      sc_error_in <= 1'b1;
      @(posedge core_clk_in);
      sc_error_in <= 1'b0;
      @(posedge core_clk_in);
    end
    rd(OFS_ERRCNT, d);
    chk(d, 32'h3);
    reg_rd_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    chk(reg_rdata_out, 32'h0);
    @(posedge core_clk_in);
    chk(reg_rdata_out, 32'h0);
    wr(OFS_MODE, 32'h1);
    wr(OFS_BAUD, 32'h2);
    wr(OFS_GUARD, 32'h2);
    wr(OFS_THOLD, 32'h0000_81A5);
    do @(posedge core_clk_in); while (tx_load_out !== 1'b1);
    chk({tx_command_out, tx_char_out}, 32'h3A5);
    wr(OFS_THOLD, 32'h0000_005A);
    rd(OFS_STATUS, d);
    chk(d & 32'h2, 32'h0);
    rd(OFS_THOLD, d);
    chk(d, 32'h0);
    wr(OFS_THOLD, 32'h0000_0033);
    do @(posedge core_clk_in); while (tx_done_in !== 1'b1);
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (tx_load_out !== 1'b1);
    chk({tx_command_out, tx_char_out}, 32'h033);
    chk(n >= 4 && n <= 8, 1);
    rd(OFS_STATUS, d);
    chk(d & 32'h2, 32'h2);
    wr(OFS_RTO, 32'h5);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, d);
    chk(d & 32'h100, 32'h0);
    repeat (20) @(posedge core_clk_in);
    rd(OFS_STATUS, d);
    chk(d & 32'h100, 32'h100);
    rx(1'b1, 9'h0C3);
    rd(OFS_RHOLD, d);
    chk(d, 32'h0000_80C3);
    rx(1'b0, 9'h111);
    rd(OFS_RHOLD, d);
    chk(d, 32'h0000_0111);
    wr(OFS_RTO, 32'h0);
    rd(OFS_STATUS, d);
    chk(d & 32'h100, 32'h0);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    chk({21'h0, tx_load_out, bit_tick_out, sample_tick_out, irda_filter_out}, 32'h0);
    rd(OFS_RATIO, d);
    chk(d, 32'h174);
    finish_test;
  end
endmodule

`default_nettype wire

// ==== ubt_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module ubt_partner
#(
  parameter int BITS = 10
)
(
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic tx_load_in,
  input  wire logic bit_tick_in,
  input  wire logic sck_run_in,
  output logic      tx_done_out,
  output logic      sck_out
);
  logic [3:0] bits_q;
  logic       busy_q;
  logic [1:0] div_q;

  // Shifter moves on bit ticks; done lands one cycle after a tick, so on a tick cycle only when ticks come every cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy_q      <= 1'b0;
      bits_q      <= '0;
      tx_done_out <= 1'b0;
      div_q       <= '0;
      sck_out     <= 1'b0;
    end else begin
      tx_done_out <= 1'b0;
      div_q       <= div_q + 2'h1;
      if (tx_load_in) begin
        busy_q <= 1'b1;
        bits_q <= '0;
      end else if (busy_q && bit_tick_in) begin
        bits_q      <= bits_q + 4'h1;
        busy_q      <= bits_q != 4'(BITS - 1);
        tx_done_out <= bits_q == 4'(BITS - 1);
      end
      // Card clock stands low while not running
      if (div_q == 2'h3) sck_out <= sck_run_in & ~sck_out;
    end
  end
endmodule

`default_nettype wire

// ==== ubt_pkg.sv ====
package ubt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RHOLD  = 8'h18;
  localparam logic [7:0] OFS_THOLD  = 8'h1C;
  localparam logic [7:0] OFS_BAUD   = 8'h20;
  localparam logic [7:0] OFS_RTO    = 8'h24;
  localparam logic [7:0] OFS_GUARD  = 8'h28;
  localparam logic [7:0] OFS_RATIO  = 8'h40;
  localparam logic [7:0] OFS_ERRCNT = 8'h44;
  localparam logic [7:0] OFS_IRF    = 8'h4C;

  // Field widths and positions
  localparam int CHR_W   = 9;
  localparam int SYNH_B  = 15;
  localparam int CD_W    = 16;
  localparam int FP_LSB  = 16;
  localparam int FP_W    = 3;
  localparam int TO_W    = 16;
  localparam int TG_W    = 8;
  localparam int RATIO_W = 11;
  localparam int ERR_W   = 8;
  localparam int IRF_W   = 8;
  localparam int OS_W    = 4;

  // Mode, control and status bits
  localparam int MODE_SYNC_B = 0;
  localparam int MODE_OVER_B = 1;
  localparam int MODE_SC_B   = 2;
  localparam int CTRL_STTO_B = 0;
  localparam int STAT_RXRDY_B = 0;
  localparam int STAT_TRANSMITTER_READY_FLAG_B = 1;
  localparam int STAT_TOUT_B  = 8;

  // Reset values and counts
  localparam logic [RATIO_W-1:0] RATIO_RST = 11'h174;
  localparam logic [OS_W-1:0]    OS16_LAST = 4'hF;
  localparam logic [OS_W-1:0]    OS8_LAST  = 4'h7;
  localparam logic [ERR_W-1:0]   ERR_MAX   = 8'hFF;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SEND  = 3'b010,
    TX_GUARD = 3'b100
  } ubt_tx_state_t;

endpackage
